// file: src/epc_creep_mon.sv
/*
 * No-load state of one energy path.
 * Assumes a level noload indication synchronous to pclk from the engine.
 */
`timescale 1ns/100ps
module epc_creep_mon (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Control and indication.
	input  wire logic detect_enable,
	input  wire logic noload,
	output logic      creep_flag
);

	// ============================================================
	// State flag
	// Detection that is switched off always reports metering.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			creep_flag <= 1'b0;
		end else begin
			creep_flag <= detect_enable & noload;
		end
	end

endmodule

// file: src/epc_defines.svh
/*
 * Constants of the energy pulse output control block: register indices,
 * field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH

// ============================================================
// Register indices; the byte address is four times the index.
`define EPC_IDX_PHASE1_HI   14'h287B
`define EPC_IDX_PHASE2_HI   14'h287C
`define EPC_IDX_CTRL4       14'h287D
`define EPC_IDX_PULSE_CTRL  14'h287E
`define EPC_IDX_CREEP       14'h287F
`define EPC_IDX_PATH_CFG    14'h2880

// ============================================================
// Field positions (low bit of each field).
`define EPC_B_CRP2_EN       7
`define EPC_B_CRP1_EN       6
`define EPC_B_PEN2          5
`define EPC_B_PEN1          4
`define EPC_B_ACC_EN        3
`define EPC_B_SWAP          2
`define EPC_B_SRC           0
`define EPC_B_RATE2         6
`define EPC_B_RATE1         4
`define EPC_B_ESEL2         2
`define EPC_B_ESEL1         0
`define EPC_B_FLAG1         7
`define EPC_B_FLAG2         6
`define EPC_B_WIDTH         4
`define EPC_B_LO2           2
`define EPC_B_LO1           0
`define EPC_B_TARGET        7
`define EPC_B_FSEL          4

// ============================================================
// Reset value of every writable field.
`define EPC_RST_FIELD       8'h00

// ============================================================
// Timing and scaling figures.
`define EPC_CLK_HZ          40000000
`define EPC_W80_MS          80
`define EPC_W40_MS          40
`define EPC_W20_MS          20
`define EPC_Q_X1            6'd16
`define EPC_Q_X4            6'd4
`define EPC_Q_X8            6'd2
`define EPC_Q_X16           6'd1
`define EPC_PHC_FSMPL_HZ    3276800
`define EPC_PHC_LSB_UDEG    5500
`define EPC_PHC_SPAN_MDEG   1400

`endif

// file: src/epc_energy_pulse_ctrl.sv
/*
 * Energy pulse output control: APB register slave, per-path creep state,
 * source and function steering, and two pulse generators with pin swap.
 * Assumes an APB master on pclk and quantum events synchronous to pclk.
 */
// Function
// - Path 2 creep detection runs only while its enable bit is 1.
// - Path 1 creep detection runs only while its enable bit is 1.
// - Path 2 pulses appear only while its pulse enable is 1.
// - Path 1 pulses appear only while its pulse enable is 1.
// - Accumulation and pulse conversion run only while accumulate enable is 1.
// - Swap bit exchanges which path drives pin A and pin B.
// - Path 1 positive source: active power, current RMS, or a constant.
// - Path 2 rate code gives x1, x4, x8 or x16.
// - Path 1 rate code gives the same four multipliers.
// - Path 2 converts positive, negative, or absolute sum energy.
// - Path 1 converts positive, negative, or absolute sum active energy.
// - Path 1 creep flag is read-only, 1 while creeping.
// - Path 2 creep flag is read-only, 1 while creeping.
// - Width code 00, 01, 10 gives 80, 40, 20 ms pulses.
// - Path 2 delay is six high bits above two low bits.
// - Path 1 delay is six high bits above two low bits.
// - One delay step is 0.0055 degree at 3.2768 MHz, about 1.4 total.
// - Path 2 role: reactive from current one, or active from current two.
// - Path 1 delay goes to voltage at 1, current one at 0.
`timescale 1ns/100ps
`include "epc_defines.svh"
module epc_energy_pulse_ctrl
	import epc_pkg::*;
#(
	parameter int unsigned CW        = 22,
	parameter int unsigned P_W80_CYC = 32'(64'(`EPC_W80_MS) * 64'(`EPC_CLK_HZ) / 64'd1000),
	parameter int unsigned P_W40_CYC = 32'(64'(`EPC_W40_MS) * 64'(`EPC_CLK_HZ) / 64'd1000),
	parameter int unsigned P_W20_CYC = 32'(64'(`EPC_W20_MS) * 64'(`EPC_CLK_HZ) / 64'd1000)
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Energy quanta from the metering engine.
	input  wire logic        p1_act_pos_evt,
	input  wire logic        p1_act_neg_evt,
	input  wire logic        p1_rms_evt,
	input  wire logic        p1_const_evt,
	input  wire logic        p2_i1_pos_evt,
	input  wire logic        p2_i1_neg_evt,
	input  wire logic        p2_i2_pos_evt,
	input  wire logic        p2_i2_neg_evt,
	// No-load indications from the metering engine.
	input  wire logic        p1_noload,
	input  wire logic        p2_noload,
	// Controls to the metering engine.
	output logic             accumulate_enable,
	output logic             path1_creep_detect_enable,
	output logic             path2_creep_detect_enable,
	output logic             path2_function_select,
	output logic             path1_delay_target,
	output logic             path2_delay_target,
	output logic      [7:0]  path1_phase_delay,
	output logic      [7:0]  path2_phase_delay,
	// Pulse pins.
	output logic             pulse_pin_a,
	output logic             pulse_pin_b
);

	// ============================================================
	// Elaboration checks
	// The width counter must hold the longest pulse, and the 40 and 20 ms counts may not be empty.
	if (CW < 2 || CW > 31) begin : g_chk_cw
		$error("CW out of range.");
	end
	if (P_W20_CYC < 1 || P_W40_CYC < 1 || P_W80_CYC >= (32'd1 << CW)) begin : g_chk_w
		$error("Pulse width counts do not fit the counter.");
	end
	// Full 8-bit delay range must come to about the documented span.
	if ((255 * `EPC_PHC_LSB_UDEG) / 1000 > `EPC_PHC_SPAN_MDEG + 5) begin : g_chk_phc
		$error("Phase step does not match the span.");
	end

	// ============================================================
	// Register fields
	logic       path2_pulse_out_enable;
	logic       path1_pulse_out_enable;
	logic       pin_swap;
	logic [1:0] source_select;
	logic [1:0] path2_rate_mult;
	logic [1:0] path1_rate_mult;
	logic [1:0] path2_energy_select;
	logic [1:0] path1_energy_select;
	logic [1:0] pulse_width_select;
	logic [1:0] path2_phase_delay_lo;
	logic [1:0] path1_phase_delay_lo;
	logic [5:0] path1_phase_delay_hi;
	logic [5:0] path2_phase_delay_hi;
	logic       path1_creep_flag;
	logic       path2_creep_flag;

	// ============================================================
	// APB decode
	logic [13:0] widx;
	logic        setup;
	logic        hit;
	logic        wr;
	logic [7:0]  wb;
	logic [7:0]  rbyte;

	assign widx  = paddr[15:2];
	assign setup = psel & ~penable;
	assign wr    = psel & penable & pready & pwrite & ~pslverr & pstrb[0];
	assign wb    = pwdata[7:0];

	// Read view of each register; reserved bits read zero.
	always_comb begin
		hit   = 1'b1;
		rbyte = 8'h00;
		case (widx)
			`EPC_IDX_PHASE1_HI: rbyte = {path1_delay_target, 1'b0, path1_phase_delay_hi};
			`EPC_IDX_PHASE2_HI: rbyte = {path2_delay_target, 1'b0, path2_phase_delay_hi};
			`EPC_IDX_CTRL4: rbyte = {path2_creep_detect_enable, path1_creep_detect_enable,
				path2_pulse_out_enable, path1_pulse_out_enable,
				accumulate_enable, pin_swap, source_select};
			`EPC_IDX_PULSE_CTRL: rbyte = {path2_rate_mult, path1_rate_mult,
				path2_energy_select, path1_energy_select};
			`EPC_IDX_CREEP: rbyte = {path1_creep_flag, path2_creep_flag,
				pulse_width_select, path2_phase_delay_lo, path1_phase_delay_lo};
			`EPC_IDX_PATH_CFG: rbyte = {3'h0, path2_function_select, 4'h0};
			default: hit = 1'b0;
		endcase
	end

	// Answer in the first access cycle; data is captured in setup so the
	// bus outputs come straight from flops at no cost in wait states.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit;
			prdata  <= (setup && hit && !pwrite) ? {24'h00_0000, rbyte} : 32'h0000_0000;
		end
	end

	// ============================================================
	// Control registers
	// Creep flags are not writable; writes to those bits are dropped.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{path2_creep_detect_enable, path1_creep_detect_enable,
				path2_pulse_out_enable, path1_pulse_out_enable,
				accumulate_enable, pin_swap, source_select} <= `EPC_RST_FIELD;
		end else if (wr && widx == `EPC_IDX_CTRL4) begin
			path2_creep_detect_enable <= wb[`EPC_B_CRP2_EN];
			path1_creep_detect_enable <= wb[`EPC_B_CRP1_EN];
			path2_pulse_out_enable    <= wb[`EPC_B_PEN2];
			path1_pulse_out_enable    <= wb[`EPC_B_PEN1];
			accumulate_enable         <= wb[`EPC_B_ACC_EN];
			pin_swap                  <= wb[`EPC_B_SWAP];
			source_select             <= wb[`EPC_B_SRC +: 2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{path2_rate_mult, path1_rate_mult,
				path2_energy_select, path1_energy_select} <= `EPC_RST_FIELD;
		end else if (wr && widx == `EPC_IDX_PULSE_CTRL) begin
			path2_rate_mult     <= wb[`EPC_B_RATE2 +: 2];
			path1_rate_mult     <= wb[`EPC_B_RATE1 +: 2];
			path2_energy_select <= wb[`EPC_B_ESEL2 +: 2];
			path1_energy_select <= wb[`EPC_B_ESEL1 +: 2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_width_select   <= 2'h0;
			path2_phase_delay_lo <= 2'h0;
			path1_phase_delay_lo <= 2'h0;
		end else if (wr && widx == `EPC_IDX_CREEP) begin
			pulse_width_select   <= wb[`EPC_B_WIDTH +: 2];
			path2_phase_delay_lo <= wb[`EPC_B_LO2 +: 2];
			path1_phase_delay_lo <= wb[`EPC_B_LO1 +: 2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			path1_delay_target   <= 1'b0;
			path1_phase_delay_hi <= 6'h00;
		end else if (wr && widx == `EPC_IDX_PHASE1_HI) begin
			path1_delay_target   <= wb[`EPC_B_TARGET];
			path1_phase_delay_hi <= wb[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			path2_delay_target   <= 1'b0;
			path2_phase_delay_hi <= 6'h00;
		end else if (wr && widx == `EPC_IDX_PHASE2_HI) begin
			path2_delay_target   <= wb[`EPC_B_TARGET];
			path2_phase_delay_hi <= wb[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			path2_function_select <= 1'b0;
		end else if (wr && widx == `EPC_IDX_PATH_CFG) begin
			path2_function_select <= wb[`EPC_B_FSEL];
		end
	end

	// ============================================================
	// Phase compensation delays
	// Both halves are flops; the engine steps its delay line at the
	// sampling rate, so one code step is one sampling period.
	assign path1_phase_delay = {path1_phase_delay_hi, path1_phase_delay_lo};
	assign path2_phase_delay = {path2_phase_delay_hi, path2_phase_delay_lo};

	// ============================================================
	// Creep state
	epc_creep_mon u_creep1 (
		.pclk          (pclk),
		.presetn       (presetn),
		.detect_enable (path1_creep_detect_enable),
		.noload        (p1_noload),
		.creep_flag    (path1_creep_flag)
	);

	epc_creep_mon u_creep2 (
		.pclk          (pclk),
		.presetn       (presetn),
		.detect_enable (path2_creep_detect_enable),
		.noload        (p2_noload),
		.creep_flag    (path2_creep_flag)
	);

	// ============================================================
	// Path steering
	epc_path_if #(.CW(CW)) p1_if ();
	epc_path_if #(.CW(CW)) p2_if ();
	logic [CW-1:0] width_cyc;

	// Code 11 is undefined; taking the shortest width keeps it safe.
	always_comb begin
		case (pulse_width_select)
			2'b00: width_cyc = CW'(P_W80_CYC);
			2'b01: width_cyc = CW'(P_W40_CYC);
			default: width_cyc = CW'(P_W20_CYC);
		endcase
	end

	// Accumulation stops while a path creeps, so no-load drift never counts.
	assign p1_if.run       = accumulate_enable & ~path1_creep_flag;
	assign p2_if.run       = accumulate_enable & ~path2_creep_flag;
	assign p1_if.pulse_en  = accumulate_enable & path1_pulse_out_enable;
	assign p2_if.pulse_en  = accumulate_enable & path2_pulse_out_enable;
	assign p1_if.rate      = path1_rate_mult;
	assign p2_if.rate      = path2_rate_mult;
	assign p1_if.esel      = path1_energy_select;
	assign p2_if.esel      = path2_energy_select;
	assign p1_if.width_cyc = width_cyc;
	assign p2_if.width_cyc = width_cyc;

	// Path 1 positive source; RMS and constant sources have no negative part.
	always_comb begin
		case (source_select)
			2'b01: begin
				p1_if.pos_evt = p1_rms_evt;
				p1_if.neg_evt = 1'b0;
			end
			2'b10: begin
				p1_if.pos_evt = p1_const_evt;
				p1_if.neg_evt = 1'b0;
			end
			default: begin
				p1_if.pos_evt = p1_act_pos_evt;
				p1_if.neg_evt = p1_act_neg_evt;
			end
		endcase
	end

	// Path 2 role: reactive from current one, or active from current two.
	assign p2_if.pos_evt = path2_function_select ? p2_i2_pos_evt : p2_i1_pos_evt;
	assign p2_if.neg_evt = path2_function_select ? p2_i2_neg_evt : p2_i1_neg_evt;

	epc_pulse_gen #(.CW(CW)) u_gen1 (
		.pclk    (pclk),
		.presetn (presetn),
		.pif     (p1_if.gen)
	);

	epc_pulse_gen #(.CW(CW)) u_gen2 (
		.pclk    (pclk),
		.presetn (presetn),
		.pif     (p2_if.gen)
	);

	// ============================================================
	// Pulse pins
	// Registered so the pins carry no decode glitches to the counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_pin_a <= 1'b0;
			pulse_pin_b <= 1'b0;
		end else begin
			pulse_pin_a <= pin_swap ? p2_if.pulse : p1_if.pulse;
			pulse_pin_b <= pin_swap ? p1_if.pulse : p2_if.pulse;
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_swap;
		$stable(pin_swap) |=>
			(pulse_pin_a == ($past(pin_swap) ? $past(p2_if.pulse) : $past(p1_if.pulse)))
			&& (pulse_pin_b == ($past(pin_swap) ? $past(p1_if.pulse) : $past(p2_if.pulse)));
	endproperty
	a_swap: assert property (p_swap) else $error("Pulse pin routing wrong.");

	property p_creep1;
		(path1_creep_detect_enable && p1_noload) |=> path1_creep_flag;
	endproperty
	a_creep1: assert property (p_creep1) else $error("Path 1 creep not flagged.");

	property p_creep2_off;
		!path2_creep_detect_enable |=> !path2_creep_flag;
	endproperty
	a_creep2_off: assert property (p_creep2_off) else $error("Path 2 creep while off.");

	property p_acc_off;
		(!accumulate_enable && !p1_if.busy) ##1 !accumulate_enable |->
			!p1_if.pulse ##1 (!pulse_pin_a || $past(pin_swap));
	endproperty
	a_acc_off: assert property (p_acc_off) else $error("Pulse while accumulation off.");

	property p_pen1;
		(!path1_pulse_out_enable && !p1_if.busy) |=> !p1_if.pulse;
	endproperty
	a_pen1: assert property (p_pen1) else $error("Path 1 pulse while disabled.");

	property p_pen2;
		(!path2_pulse_out_enable && !p2_if.busy) |=> !p2_if.pulse;
	endproperty
	a_pen2: assert property (p_pen2) else $error("Path 2 pulse while disabled.");

	property p_apb;
		setup |=> pready ##1 !pready;
	endproperty
	a_apb: assert property (p_apb) else $error("APB answer timing wrong.");

endmodule

// file: src/epc_path_if.sv
/*
 * Carrier between the control top and one pulse generator.
 * Assumes the top drives the control side and reads the pulse back.
 */
`timescale 1ns/100ps
interface epc_path_if #(parameter int unsigned CW = 22);
	logic          run;
	logic          pulse_en;
	logic [1:0]    rate;
	logic [1:0]    esel;
	logic [CW-1:0] width_cyc;
	logic          pos_evt;
	logic          neg_evt;
	logic          pulse;
	logic          busy;

	modport ctrl (output run, pulse_en, rate, esel, width_cyc, pos_evt, neg_evt,
		input pulse, busy);
	modport gen (input run, pulse_en, rate, esel, width_cyc, pos_evt, neg_evt,
		output pulse, busy);
endinterface

// file: src/epc_pkg.sv
/*
 * Types shared by the energy pulse output control block.
 * Assumes nothing of its surroundings.
 */
package epc_pkg;

	// Energy-to-pulse selection codes; both other codes mean the absolute sum.
	typedef enum logic [1:0] {
		epc_esel_sum0,
		epc_esel_pos,
		epc_esel_neg,
		epc_esel_sum3
	} epc_esel_t;

	// States of one pulse generator.
	typedef enum logic [1:0] {
		epc_st_idle,
		epc_st_high,
		epc_st_gap
	} epc_pstate_t;

endpackage

// file: src/epc_pulse_gen.sv
/*
 * Pulse generator of one energy path: counts energy quanta, divides them
 * by 16, 4, 2 or 1 for rate x1, x4, x8 or x16 and shapes pulses of the selected width.
 * Assumes one-cycle quantum events and a width of at least one cycle.
 */
`timescale 1ns/100ps
`include "epc_defines.svh"
module epc_pulse_gen
	import epc_pkg::*;
#(
	parameter int unsigned CW = 22
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Path control and pulse.
	epc_path_if.gen   pif
);

	logic [5:0]    quota;
	logic [5:0]    inc;
	logic [5:0]    sum;
	logic [5:0]    cnt;
	logic          due;
	logic [CW-1:0] wcnt;
	logic [CW-1:0] wlat;
	logic [CW-1:0] hi_len;
	logic          pending;
	epc_pstate_t   state;

	// ============================================================
	// Elaboration check
	// The width counter must hold a count of at least one cycle.
	if (CW < 2 || CW > 31) begin : g_chk_cw
		$error("CW out of range.");
	end

	// ============================================================
	// Quantum counting
	// A faster rate simply needs fewer quanta per pulse.
	always_comb begin
		case (pif.rate)
			2'b00: quota = `EPC_Q_X1;
			2'b01: quota = `EPC_Q_X4;
			2'b10: quota = `EPC_Q_X8;
			default: quota = `EPC_Q_X16;
		endcase
		inc = 6'h00;
		if (pif.run) begin
			case (epc_esel_t'(pif.esel))
				epc_esel_pos: inc = {5'h00, pif.pos_evt};
				epc_esel_neg: inc = {5'h00, pif.neg_evt};
				default: inc = {5'h00, pif.pos_evt} + {5'h00, pif.neg_evt};
			endcase
		end
		sum = cnt + inc;
		due = (sum >= quota);
	end

	// The remainder carries over so no quantum is lost at a pulse boundary.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 6'h00;
		end else if (due) begin
			cnt <= sum - quota;
		end else begin
			cnt <= sum;
		end
	end

	// ============================================================
	// Pulse shaping
	// A running pulse always completes; a one-cycle gap separates pulses.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= epc_st_idle;
			wcnt    <= '0;
			wlat    <= '0;
			pending <= 1'b0;
		end else begin
			case (state)
				epc_st_idle: begin
					if (due && pif.pulse_en) begin
						state <= epc_st_high;
						wcnt  <= pif.width_cyc - 1'b1;
						wlat  <= pif.width_cyc;
					end
				end
				epc_st_high: begin
					pending <= pending | (due & pif.pulse_en);
					if (wcnt == '0) begin
						state <= epc_st_gap;
					end else begin
						wcnt <= wcnt - 1'b1;
					end
				end
				epc_st_gap: begin
					pending <= 1'b0;
					if (pending && pif.pulse_en) begin
						state <= epc_st_high;
						wcnt  <= pif.width_cyc - 1'b1;
						wlat  <= pif.width_cyc;
					end else begin
						state <= epc_st_idle;
					end
				end
				default: state <= epc_st_idle;
			endcase
		end
	end

	assign pif.pulse = (state == epc_st_high);
	assign pif.busy  = (state != epc_st_idle);

	// ============================================================
	// Checks
	// Length of the current high phase, read only by the width check.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_len <= '0;
		end else begin
			hi_len <= (state == epc_st_high) ? hi_len + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_width;
		$fell(pif.pulse) |-> (hi_len == wlat);
	endproperty
	a_width: assert property (p_width) else $error("Pulse width differs from selection.");

	property p_neg_only;
		(pif.esel == 2'b10 && pif.pos_evt && !pif.neg_evt && !due) |=> (cnt == $past(cnt));
	endproperty
	a_neg_only: assert property (p_neg_only) else $error("Positive quantum counted.");

	property p_quota;
		(pif.run && pif.rate == 2'b11 && pif.esel == 2'b01 && pif.pos_evt && cnt == 6'h00)
			|-> due;
	endproperty
	a_quota: assert property (p_quota) else $error("Rate x16 missed a pulse.");

endmodule

// file: test/epc_pulse_cnt.sv
/* Pulse counter standing at the two pulse pins.
   Assumes active-high pins registered on pclk. */
`timescale 1ns/100ps
module epc_pulse_cnt (
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Pins and counts.
	input  wire logic       pin_a,
	input  wire logic       pin_b,
	output logic      [7:0] cnt_a,
	output logic      [7:0] cnt_b,
	output logic      [7:0] wid_a
);
	// ==========
	logic [1:0] last;
	logic [7:0] run;

	// Rising edges are counted; each high stretch on pin A is timed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cnt_a, cnt_b, wid_a, run, last} <= '0;
		end else begin
			last <= {pin_b, pin_a};
			cnt_a <= cnt_a + 8'(pin_a & !last[0]);
			cnt_b <= cnt_b + 8'(pin_b & !last[1]);
			run <= pin_a ? run + 8'h01 : 8'h00;
			if (!pin_a && last[0]) begin
				wid_a <= run;
			end
		end
	end
endmodule

// file: test/testbench.sv
/* Self-checking bench of the energy pulse control block.
   Assumes short pulse widths of 8, 4 and 2 cycles. */
`timescale 1ns/100ps
`include "epc_defines.svh"
module testbench;
	// ==========
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        acc, c1, c2, t1, t2, fs, pa, pb;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  evts, ca, cb, wa, d1, d2, ph1, ph2;
	logic [1:0]  nl;
	int          num_errors, check_count, cyc;

	epc_energy_pulse_ctrl #(.P_W80_CYC(8), .P_W40_CYC(4), .P_W20_CYC(2)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
		.pready, .pslverr, .p1_act_pos_evt(evts[0]), .p1_act_neg_evt(evts[1]),
		.p1_rms_evt(evts[2]), .p1_const_evt(evts[3]), .p2_i1_pos_evt(evts[4]),
		.p2_i1_neg_evt(evts[5]), .p2_i2_pos_evt(evts[6]), .p2_i2_neg_evt(evts[7]),
		.p1_noload(nl[0]), .p2_noload(nl[1]), .accumulate_enable(acc),
		.path1_creep_detect_enable(c1), .path2_creep_detect_enable(c2),
		.path2_function_select(fs), .path1_delay_target(t1), .path2_delay_target(t2),
		.path1_phase_delay(ph1), .path2_phase_delay(ph2), .pulse_pin_a(pa), .pulse_pin_b(pb));
	epc_pulse_cnt partner (.pclk, .presetn, .pin_a(pa), .pin_b(pb), .cnt_a(ca), .cnt_b(cb),
		.wid_a(wa));

	// Clock; the cycle ceiling stops a hung run.
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			report_and_stop;
		end
	end

	function automatic logic [7:0] quanta(input logic [1:0] r);
		return (r == 2'h0) ? 8'h10 : (r == 2'h1) ? 8'h04 : (r == 2'h2) ? 8'h02 : 8'h01;
	endfunction
	function automatic logic [7:0] wexp(input logic [1:0] w);
		return (w == 2'h0) ? 8'h08 : (w == 2'h1) ? 8'h04 : 8'h02;
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// One APB transfer; held until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [13:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rst;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Fresh start, setup, n events spaced wider than a pulse, pin counts checked.
	task automatic run(input logic [7:0] c4, pc, cr, cfg, input logic [1:0] n_l,
		input logic [7:0] m, input int n, input logic [7:0] ea, eb);
		rst;
		nl <= n_l;
		apb(1'b1, `EPC_IDX_CTRL4, c4);
		apb(1'b1, `EPC_IDX_PULSE_CTRL, pc);
		apb(1'b1, `EPC_IDX_CREEP, cr);
		apb(1'b1, `EPC_IDX_PATH_CFG, cfg);
		repeat (n) begin
			@(posedge pclk);
			evts <= m;
			@(posedge pclk);
			evts <= 8'h00;
			repeat (12) @(posedge pclk);
		end
		repeat (20) @(posedge pclk);
		chk("pin_a count", 32'(ea), 32'(ca));
		chk("pin_b count", 32'(eb), 32'(cb));
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		{psel, penable, pwrite, paddr, pwdata, evts, nl} = '0;
		{presetn, num_errors, check_count, cyc} = '0;
		void'($urandom(32'hF9F5));
		rst;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 14'(`EPC_IDX_PHASE1_HI + i), 8'h00);
			chk("reset value", 32'h0, rd);
		end
		apb(1'b1, 14'h2881, 8'hFF);
		chk("unmapped error", 32'h1, 32'(err));
		$display("test reset done");
		repeat (4) begin
			d1 = 8'($urandom);
			d2 = 8'($urandom);
			apb(1'b1, `EPC_IDX_CTRL4, d1);
			apb(1'b0, `EPC_IDX_CTRL4, 8'h00);
			chk("ctrl4", {24'h0, d1}, rd);
			chk("ctrl4 outputs", {29'h0, d1[7:6], d1[3]}, {29'h0, c2, c1, acc});
			apb(1'b1, `EPC_IDX_PHASE1_HI, d2);
			apb(1'b1, `EPC_IDX_PHASE2_HI, ~d2);
			apb(1'b1, `EPC_IDX_CREEP, d1);
			apb(1'b0, `EPC_IDX_CREEP, 8'h00);
			chk("creep reg", {26'h0, d1[5:0]}, rd);
			chk("phase1", {24'h0, d2[5:0], d1[1:0]}, {24'h0, ph1});
			chk("phase2", {24'h0, ~d2[5:0], d1[3:2]}, {24'h0, ph2});
			chk("target", {31'h0, d2[7]}, {31'h0, t1});
			chk("target2", {31'h0, ~d2[7]}, {31'h0, t2});
		end
		nl <= 2'b11;
		for (int e = 0; e < 4; e++) begin
			apb(1'b1, `EPC_IDX_CTRL4, 8'(e << 6));
			apb(1'b0, `EPC_IDX_CREEP, 8'h00);
			chk("creep flags", {30'h0, 1'(e), 1'(e >> 1)}, {30'h0, rd[7:6]});
		end
		$display("test registers done");
		for (int p = 0; p < 2; p++) begin
			for (int r = 0; r < 4; r++) begin
				run(8'h38, 8'(r << (4 + 2 * p)) | 8'h05, 8'h00, 8'h00, 2'b00, p ? 8'h10 : 8'h01,
					2 * quanta(2'(r)), p ? 8'h00 : 8'h02, p ? 8'h02 : 8'h00);
			end
			for (int e = 0; e < 8; e++) begin
				run(8'h38, p ? 8'hC0 | 8'((e % 4) << 2) : 8'h30 | 8'(e % 4), 8'h00, 8'h00, 2'b00,
					(p ? 8'h10 : 8'h01) << (e / 4), 1, p ? 8'h00 : 8'((e / 4) ? e % 4 != 1 :
					e % 4 != 2), p ? 8'((e / 4) ? e % 4 != 1 : e % 4 != 2) : 8'h00);
			end
		end
		for (int s = 0; s < 12; s++) begin
			run(8'h18 | 8'(s % 4), 8'h31, 8'h00, 8'h00, 2'b00, 8'h01 << (s / 4 + (s >= 4)), 1,
				8'((s / 4 == 0 && (s % 4 == 0 || s % 4 == 3)) || s / 4 == s % 4), 8'h00);
		end
		for (int w = 0; w < 4; w++) begin
			run(8'h18, 8'h31, 8'(w << 4), 8'h00, 2'b00, 8'h01, 1, 8'h01, 8'h00);
			chk("pulse width", 32'(wexp(2'(w))), 32'(wa));
		end
		$display("test pulse rates and widths done");
		run(8'h1C, 8'h31, 8'h00, 8'h00, 2'b00, 8'h01, 1, 8'h00, 8'h01);
		run(8'h2C, 8'hC4, 8'h00, 8'h00, 2'b00, 8'h10, 1, 8'h01, 8'h00);
		run(8'h10, 8'h31, 8'h00, 8'h00, 2'b00, 8'h01, 1, 8'h00, 8'h00);
		run(8'h08, 8'h31, 8'h00, 8'h00, 2'b00, 8'h01, 1, 8'h00, 8'h00);
		run(8'h58, 8'h31, 8'h00, 8'h00, 2'b01, 8'h01, 1, 8'h00, 8'h00);
		run(8'hA8, 8'hC4, 8'h00, 8'h00, 2'b10, 8'h10, 1, 8'h00, 8'h00);
		run(8'h28, 8'hC4, 8'h00, 8'h10, 2'b00, 8'h40, 1, 8'h00, 8'h01);
		chk("function select", 32'h1, 32'(fs));
		$display("test routing and gating done");
		report_and_stop;
	end
endmodule
